// File: src/pdm_pkg.sv
// Shared constants for the operating-mode controller
package pdm_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00; // Mode selection bits
    localparam logic [7:0] OFS_MODSTBY = 8'h04; // Per-module standby
    localparam logic [7:0] OFS_STATUS  = 8'h08; // Current mode, read only
    localparam logic [7:0] OFS_PSCNT   = 8'h0c; // Wake and retention view

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int CTRL_SUBCORE = 0; // subclock_core_select
    localparam int CTRL_MEDSPD  = 1; // medium_speed_select
    localparam int CTRL_STBY    = 2; // deep_standby_select
    localparam int CTRL_WATCHTB = 3; // watch_timebase_select
    localparam int CTRL_DIRECT  = 4; // direct_transition_select
    localparam int CTRL_DIV_LO  = 5; // Medium divider select, 2 bits
    localparam int CTRL_W       = 7; // Width of the control field

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0]  CTRL_RST    = 7'h00;
    localparam logic [10:0] MODSTBY_RST = 11'h000;

    // ------------------------------------------------------------
    // Peripheral index, one bit per gated module
    // ------------------------------------------------------------
    localparam int NPER = 11;
    // 0 time base, 1 timer c, 2 timer f, 3 timer g, 4 watchdog_timer,
    // 5 serial_interface_one, 6 serial_interface_two,
    // 7 async_event_counter, 8 display driver, 9 pwm, 10 adc
    localparam logic [10:0] PER_ALL      = 11'h7ff;
    localparam logic [10:0] PER_SUBCLK   = 11'h1ff; // Subactive and subsleep set
    localparam logic [10:0] PER_WATCH    = 11'h18d; // Time base, f, g, counter, display
    localparam int          PER_AEC      = 7;

    // ------------------------------------------------------------
    // Interrupt source index and wake groups
    // ------------------------------------------------------------
    localparam int NSRC = 24;
    // 0 time base, 1 timer c, 2 timer f, 3 timer g, 4 serial one,
    // 5 serial two, 6 async_event_counter, 7..11 ext lines 0..4,
    // 12..19 wakeup_pin_interrupt 0..7, 20..23 other sources
    localparam int          SRC_EXT0 = 7;
    localparam logic [23:0] WAKE_GRP1 = 24'h0ff08d;
    localparam logic [23:0] WAKE_GRP2 = 24'h0fffff;
    localparam logic [23:0] WAKE_GRP3 = 24'hffffff;
    localparam logic [23:0] WAKE_GRP4 = 24'h0ff180;

    // Ignored external lines per mode, bit n is line n
    localparam logic [4:0] EXT_IGN_WATCH = 5'h1e; // Lines 4..1
    localparam logic [4:0] EXT_IGN_STBY  = 5'h1c; // Lines 4..2

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    localparam int          PSS_W   = 13;
    localparam logic [12:0] PSS_RST = 13'h0000;

    // Operating modes; module standby is orthogonal to these
    typedef enum logic [3:0] {
        M_ACT_HIGH,
        M_ACT_MED,
        M_SUBACT,
        M_SLP_HIGH,
        M_SLP_MED,
        M_SUBSLP,
        M_WATCH,
        M_STBY,
        M_WAKING
    } mode_e;

endpackage : pdm_pkg

// File: src/system_clock_prescaler.sv
// Free-running system clock prescaler with divided tick output
`timescale 1ns/10ps
module system_clock_prescaler #(
    parameter int W = 13
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic [1:0]   div_sel,
    output logic      [W-1:0] count,
    output logic              tick
);

    // ------------------------------------------------------------
    // Divider mask, selects one of 1/8, 1/16, 1/32, 1/64
    // ------------------------------------------------------------
    function automatic logic [W-1:0] div_mask(input logic [1:0] sel);
        logic [W-1:0] m;
        m = {W{1'b0}};
        case (sel)
            2'h0:    m = W'(13'h0007);
            2'h1:    m = W'(13'h000f);
            2'h2:    m = W'(13'h001f);
            default: m = W'(13'h003f);
        endcase
        return m;
    endfunction : div_mask

    // Counter stops and clears whenever the oscillator is off
    always_ff @(posedge clk_sys)
    begin
        if (rst || !run)
            count <= pdm_pkg::PSS_RST[W-1:0];
        else
            count <= count + W'(1);
    end

    // One-cycle tick at the selected fraction
    always_comb
    begin
        tick = run && ((count & div_mask(div_sel)) == div_mask(div_sel));
    end

endmodule : system_clock_prescaler

// File: src/power_down_mode_controller.sv
// Operating-mode controller with AHB-Lite register slave
`timescale 1ns/10ps
module power_down_mode_controller (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Processor core side
    input  wire logic        sleep_req,
    input  wire logic        irq_accepted,
    input  wire logic [23:0] irq_src,
    output logic             core_run,
    output logic             core_on_subclock,
    output logic             core_tick,
    output logic             wake_req,
    // Peripheral side
    output logic      [10:0] per_run,
    output logic             per_on_subclock,
    output logic             per_tick,
    output logic      [12:0] prescaler_count,
    output logic             sysclk_osc_run,
    output logic             port_hiz,
    output logic      [4:0]  ext_irq_ignore,
    output logic             aec_irq_block
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pdm_pkg::mode_e mode_q;        // Current operating mode
    pdm_pkg::mode_e ret_q;         // Mode to resume after a wake
    pdm_pkg::mode_e target;        // Decoded target of a sleep request
    pdm_pkg::mode_e resume;        // Active mode after wake from mode_q
    logic [6:0]     ctrl_q;        // Control bits
    logic [10:0]    modstby_q;     // Per-module standby bits
    logic [7:0]     addr_q;        // Latched address of data phase
    logic           wr_q;          // Write pending in data phase
    logic           ph_valid;      // Address phase being accepted
    logic [23:0]    wake_mask;     // Sources allowed to wake now
    logic [23:0]    wake_hit_q;    // Captured wake sources, for status
    logic           osc_run;       // System oscillator enable
    logic           ps_tick;       // Divided tick from the prescaler
    logic [10:0]    mode_per;      // Peripherals running by mode

    // ------------------------------------------------------------
    // Bus slave always ready, always OKAY
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Accept only active transfers while the bus is ready
    assign ph_valid = hsel && hready && htrans[1];

    // ------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------
    // Writes land one cycle later, in the data phase
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end
        else if (hready)
        begin
            addr_q <= haddr[7:0];
            wr_q   <= ph_valid && hwrite;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Mode bits are sampled at a sleep request and again at a wake
    // from watch or standby; the divider bits act at once
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ctrl_q <= pdm_pkg::CTRL_RST;
        else if (wr_q && addr_q == pdm_pkg::OFS_CTRL)
            ctrl_q <= hwdata[6:0];
    end

    // ------------------------------------------------------------
    // Module standby register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            modstby_q <= pdm_pkg::MODSTBY_RST;
        else if (wr_q && addr_q == pdm_pkg::OFS_MODSTBY)
            modstby_q <= hwdata[10:0];
    end

    // ------------------------------------------------------------
    // Read data, registered at the address phase
    // ------------------------------------------------------------
    // Unmapped offsets read as zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (ph_valid && !hwrite)
        begin
            case (haddr[7:0])
                pdm_pkg::OFS_CTRL:    hrdata <= {25'h0, ctrl_q};
                pdm_pkg::OFS_MODSTBY: hrdata <= {21'h0, modstby_q};
                pdm_pkg::OFS_STATUS:  hrdata <= {28'h0, mode_q};
                pdm_pkg::OFS_PSCNT:   hrdata <= {8'h00, wake_hit_q};
                default:              hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Target decode at the sleep instruction
    // ------------------------------------------------------------
    // Subclock and timebase bits pick subclock modes, standby bit
    // picks the stopped modes, direct bit skips the sleep stage
    always_comb
    begin
        target = mode_q;
        if (!ctrl_q[pdm_pkg::CTRL_DIRECT])
        begin
            // Sleep-type destinations
            if (!ctrl_q[pdm_pkg::CTRL_STBY])
            begin
                if (ctrl_q[pdm_pkg::CTRL_SUBCORE] && ctrl_q[pdm_pkg::CTRL_WATCHTB])
                    target = pdm_pkg::M_SUBSLP;
                else if (!ctrl_q[pdm_pkg::CTRL_SUBCORE] && ctrl_q[pdm_pkg::CTRL_MEDSPD])
                    target = pdm_pkg::M_SLP_MED;
                else if (!ctrl_q[pdm_pkg::CTRL_SUBCORE])
                    target = pdm_pkg::M_SLP_HIGH;
            end
            else if (ctrl_q[pdm_pkg::CTRL_WATCHTB])
                target = pdm_pkg::M_WATCH;
            else if (!ctrl_q[pdm_pkg::CTRL_SUBCORE])
                target = pdm_pkg::M_STBY;
        end
        else
        begin
            // Direct transitions between running modes
            if (ctrl_q[pdm_pkg::CTRL_SUBCORE] && ctrl_q[pdm_pkg::CTRL_STBY]
                && ctrl_q[pdm_pkg::CTRL_WATCHTB])
                target = pdm_pkg::M_SUBACT;
            else if (!ctrl_q[pdm_pkg::CTRL_SUBCORE]
                     && (!ctrl_q[pdm_pkg::CTRL_STBY] || ctrl_q[pdm_pkg::CTRL_WATCHTB]))
                target = ctrl_q[pdm_pkg::CTRL_MEDSPD] ? pdm_pkg::M_ACT_MED
                                                      : pdm_pkg::M_ACT_HIGH;
        end
    end

    // ------------------------------------------------------------
    // Resume mode after a wake
    // ------------------------------------------------------------
    // Sleep returns to its own active speed; the stopped modes
    // follow the speed bits as they stand at wake
    always_comb
    begin
        case (mode_q)
            pdm_pkg::M_SLP_HIGH: resume = pdm_pkg::M_ACT_HIGH;
            pdm_pkg::M_SLP_MED:  resume = pdm_pkg::M_ACT_MED;
            pdm_pkg::M_SUBSLP:   resume = pdm_pkg::M_SUBACT;
            default:
            begin
                if (ctrl_q[pdm_pkg::CTRL_SUBCORE])
                    resume = pdm_pkg::M_SUBACT;
                else if (ctrl_q[pdm_pkg::CTRL_MEDSPD])
                    resume = pdm_pkg::M_ACT_MED;
                else
                    resume = pdm_pkg::M_ACT_HIGH;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Wake source groups per halted mode
    // ------------------------------------------------------------
    always_comb
    begin
        case (mode_q)
            pdm_pkg::M_SLP_HIGH,
            pdm_pkg::M_SLP_MED: wake_mask = pdm_pkg::WAKE_GRP3;
            pdm_pkg::M_SUBSLP:  wake_mask = pdm_pkg::WAKE_GRP2;
            pdm_pkg::M_WATCH:   wake_mask = pdm_pkg::WAKE_GRP1;
            pdm_pkg::M_STBY:    wake_mask = pdm_pkg::WAKE_GRP4;
            default:            wake_mask = 24'h000000;
        endcase
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    // A wake moves to the waking mode, which restarts the clocks;
    // the resume mode is entered only once the core reports it took
    // the interrupt, so a request that is withdrawn never resumes by itself
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_q <= pdm_pkg::M_ACT_HIGH;
            ret_q  <= pdm_pkg::M_ACT_HIGH;
        end
        else
        begin
            case (mode_q)
                pdm_pkg::M_ACT_HIGH,
                pdm_pkg::M_ACT_MED,
                pdm_pkg::M_SUBACT:
                begin
                    // Sleep instruction uses the bits of this cycle
                    if (sleep_req)
                        mode_q <= target;
                end
                pdm_pkg::M_SLP_HIGH,
                pdm_pkg::M_SLP_MED,
                pdm_pkg::M_SUBSLP,
                pdm_pkg::M_WATCH,
                pdm_pkg::M_STBY:
                begin
                    if ((irq_src & wake_mask) != 24'h000000)
                    begin
                        ret_q  <= resume;
                        mode_q <= pdm_pkg::M_WAKING;
                    end
                end
                pdm_pkg::M_WAKING:
                begin
                    // Handler accepted; transition completes
                    if (irq_accepted)
                        mode_q <= ret_q;
                end
                default: mode_q <= pdm_pkg::M_ACT_HIGH;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Captured wake sources, kept until the next sleep request
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            wake_hit_q <= 24'h000000;
        else if (sleep_req && mode_q != pdm_pkg::M_WAKING)
            wake_hit_q <= 24'h000000;
        else if (wake_mask != 24'h000000)
            wake_hit_q <= wake_hit_q | (irq_src & wake_mask);
    end

    // ------------------------------------------------------------
    // Core clocking
    // ------------------------------------------------------------
    // Core runs in active modes and while waking, never in sleep
    always_comb
    begin
        case (mode_q)
            pdm_pkg::M_ACT_HIGH,
            pdm_pkg::M_ACT_MED,
            pdm_pkg::M_SUBACT,
            pdm_pkg::M_WAKING:  core_run = 1'b1;
            default:            core_run = 1'b0;
        endcase
    end

    // Subclock drives the core in subclock-active mode
    assign core_on_subclock = (mode_q == pdm_pkg::M_SUBACT);

    // Full rate in high speed, divided tick in medium speed
    assign core_tick = core_run && !core_on_subclock
                       && ((mode_q == pdm_pkg::M_ACT_MED) ? ps_tick : 1'b1);

    // Wake indication to the core, held until it takes the interrupt
    assign wake_req = (mode_q == pdm_pkg::M_WAKING);

    // ------------------------------------------------------------
    // Peripheral clocking by mode
    // ------------------------------------------------------------
    always_comb
    begin
        case (mode_q)
            pdm_pkg::M_SUBACT,
            pdm_pkg::M_SUBSLP: mode_per = pdm_pkg::PER_SUBCLK;
            pdm_pkg::M_WATCH:  mode_per = pdm_pkg::PER_WATCH;
            pdm_pkg::M_STBY:   mode_per = 11'h000;
            default:           mode_per = pdm_pkg::PER_ALL;
        endcase
    end

    // Software standby masks on top of the mode set
    assign per_run = mode_per & ~modstby_q;

    // Subclock modes put the running peripherals on the subclock
    assign per_on_subclock = (mode_q == pdm_pkg::M_SUBACT) || (mode_q == pdm_pkg::M_SUBSLP)
                             || (mode_q == pdm_pkg::M_WATCH) || (mode_q == pdm_pkg::M_STBY);

    // Divided tick in both medium modes, none while the oscillator is stopped, else every cycle
    assign per_tick = osc_run && (((mode_q == pdm_pkg::M_ACT_MED)
                                   || (mode_q == pdm_pkg::M_SLP_MED)) ? ps_tick : 1'b1);

    // ------------------------------------------------------------
    // System oscillator and prescaler
    // ------------------------------------------------------------
    // Waking from a stopped mode restarts the oscillator at once,
    // so the handler runs on the system clock
    assign osc_run = !per_on_subclock && !core_on_subclock;
    assign sysclk_osc_run = osc_run;

    // Prescaler clears itself while the oscillator is stopped
    system_clock_prescaler #(
        .W (pdm_pkg::PSS_W)
    ) u_prescaler (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (osc_run),
        .div_sel (ctrl_q[pdm_pkg::CTRL_DIV_LO +: 2]),
        .count   (prescaler_count),
        .tick    (ps_tick)
    );

    // ------------------------------------------------------------
    // Port and interrupt retention
    // ------------------------------------------------------------
    // Port registers stay untouched; only the drivers are released
    assign port_hiz = (mode_q == pdm_pkg::M_STBY);

    // Ignored lines must not set their request flags
    always_comb
    begin
        case (mode_q)
            pdm_pkg::M_WATCH: ext_irq_ignore = pdm_pkg::EXT_IGN_WATCH;
            pdm_pkg::M_STBY:  ext_irq_ignore = pdm_pkg::EXT_IGN_STBY;
            default:          ext_irq_ignore = 5'h00;
        endcase
    end

    // Event counter keeps counting in watch mode, stops in standby, and may not interrupt in either
    assign aec_irq_block = (mode_q == pdm_pkg::M_WATCH)
                           || (mode_q == pdm_pkg::M_STBY);

endmodule : power_down_mode_controller

// File: tb/pdm_asserts.sv
// Port-level checks for the operating-mode controller
`timescale 1ns/10ps
module pdm_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        sleep_req,
    input wire logic        irq_accepted,
    input wire logic        core_run,
    input wire logic        core_on_subclock,
    input wire logic        core_tick,
    input wire logic        wake_req,
    input wire logic [10:0] per_run,
    input wire logic        per_on_subclock,
    input wire logic [12:0] prescaler_count,
    input wire logic        sysclk_osc_run,
    input wire logic        port_hiz,
    input wire logic [4:0]  ext_irq_ignore,
    input wire logic        aec_irq_block
);
    // One clock domain, so one default clocking and reset for all
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_halt_cause: assert property ($fell(core_run) |-> $past(sleep_req))
        else $error("core halted without a sleep request");
    a_wake_hold: assert property (wake_req && !irq_accepted |=> wake_req)
        else $error("wake finished before the interrupt was accepted");
    a_wake_clock: assert property (wake_req |-> core_run && core_tick && sysclk_osc_run)
        else $error("core not clocked while waking");
    a_halt_tick: assert property (!core_run |-> !core_tick)
        else $error("halted core still ticking");
    a_sub_core: assert property (core_on_subclock |-> core_run && !sysclk_osc_run && !core_tick)
        else $error("subclock core mode has a bad clock view");
    a_osc_stop: assert property (!sysclk_osc_run && !$past(sysclk_osc_run) |-> prescaler_count == 13'h0000 && per_on_subclock)
        else $error("prescaler not cleared with oscillator stopped");
    a_pss_count: assert property (sysclk_osc_run && $past(sysclk_osc_run) && !$past(rst)
        |-> prescaler_count == $past(prescaler_count) + 13'h0001)
        else $error("prescaler did not advance by one");
    a_watch_set: assert property (ext_irq_ignore == 5'h1e |-> aec_irq_block && !core_run && (per_run & ~pdm_pkg::PER_WATCH) == 11'h000)
        else $error("watch mode outputs inconsistent");
    a_stby_set: assert property (port_hiz |-> ext_irq_ignore == 5'h1c && aec_irq_block && !core_run && per_run == 11'h000)
        else $error("standby mode outputs inconsistent");
endmodule : pdm_asserts

// File: tb/core_model.sv
// Behavioural processor core: sleep instruction and interrupt acceptance
`timescale 1ns/10ps
module core_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       cmd_sleep,
    input  wire logic [3:0] accept_dly,
    input  wire logic       wake_req,
    output logic            sleep_req,
    output logic            irq_accepted
);
    logic [3:0] wait_q; // Cycles spent in the handler before accepting
    // Sleep instruction, one cycle per bench command
    always_ff @(posedge clk_sys)
        sleep_req <= rst ? 1'b0 : cmd_sleep;
    // Handler delay; a slow core shows that a raised request alone never resumes
    always_ff @(posedge clk_sys)
        wait_q <= (rst || !wake_req) ? 4'h0 : wait_q + 4'h1;
    always_ff @(posedge clk_sys)
        irq_accepted <= !rst && wake_req && wait_q == accept_dly;
endmodule : core_model

// File: tb/power_down_mode_controller_tb.sv
// Self-checking bench for the operating-mode controller
`timescale 1ns/10ps
module power_down_mode_controller_tb;
    logic        clk_sys, rst, hsel, hwrite, cmd_sleep, hreadyout, hresp, sleep_req, irq_accepted;
    logic        core_run, core_on_subclock, core_tick, wake_req, per_on_subclock, per_tick;
    logic        sysclk_osc_run, port_hiz, aec_irq_block;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [23:0] irq_src;
    logic [3:0]  accept_dly;
    logic [10:0] per_run;
    logic [12:0] prescaler_count;
    logic [4:0]  ext_irq_ignore;
    int          n_fail, comparisons;
    power_down_mode_controller dut_u (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_req, .irq_accepted, .irq_src, .core_run,
        .core_on_subclock, .core_tick, .wake_req, .per_run, .per_on_subclock, .per_tick, .prescaler_count,
        .sysclk_osc_run, .port_hiz, .ext_irq_ignore, .aec_irq_block);
    core_model core_u (.clk_sys, .rst, .cmd_sleep, .accept_dly, .wake_req, .sleep_req, .irq_accepted);
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish;
        $display("Counts: %0d compared, %0d mismatched", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // Waits at edges until the slave is ready; bounded
    task automatic edge_rdy;
        int i;
        for (i = 0; i == 0 || (hreadyout !== 1'b1 && i < 32); i++)
            @(posedge clk_sys);
        chk(hreadyout, 1'b1, "bus ready");
        chk(hresp, 1'b0, "okay response");
        if (hreadyout !== 1'b1) tally_and_finish;
    endtask : edge_rdy
    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
        edge_rdy;
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        edge_rdy;
        rd = hrdata;
    endtask : bus
    task automatic wait_wake(input logic v);
        for (int i = 0; i < 64 && wake_req !== v; i++)
            @(negedge clk_sys);
        chk(wake_req, v, "wake wait");
        if (wake_req !== v) tally_and_finish;
    endtask : wait_wake
    task automatic sleep_now;
        @(posedge clk_sys);
        cmd_sleep <= 1'b1;
        @(posedge clk_sys);
        cmd_sleep <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : sleep_now
    // Reset values, read-only and unmapped places, module standby
    task automatic t_regs;
        bus(0, pdm_pkg::OFS_CTRL, 0);
        chk(rd, 0, "control reset");
        bus(1, 32'h10, 32'hffffffff);
        bus(0, 32'h10, 0);
        chk(rd, 0, "unmapped read");
        bus(1, pdm_pkg::OFS_STATUS, 32'h5);
        bus(0, pdm_pkg::OFS_STATUS, 0);
        chk(rd, pdm_pkg::M_ACT_HIGH, "status read only");
        chk(per_run, pdm_pkg::PER_ALL, "all running");
        bus(1, pdm_pkg::OFS_MODSTBY, 32'h0a5);
        bus(0, pdm_pkg::OFS_MODSTBY, 0);
        chk(per_run, 11'h7ff & ~11'h0a5, "module standby");
        bus(1, pdm_pkg::OFS_MODSTBY, 0);
        $display("register test done");
    endtask : t_regs
    // Enter a mode from control bits, check it, refuse a stray source, then wake
    task automatic sleep_to(input logic [6:0] c, input pdm_pkg::mode_e m, input logic [10:0] pr,
                            input int wk, input int bad, input int tk, input pdm_pkg::mode_e res);
        int n;
        bus(1, pdm_pkg::OFS_CTRL, {25'h0, c});
        sleep_now;
        bus(0, pdm_pkg::OFS_STATUS, 0);
        chk(rd, {28'h0, m}, "mode entered");
        chk(per_run, pr, "peripheral set");
        n = 0;
        for (int i = 0; i < 128 && tk >= 0; i++)
        begin
            @(negedge clk_sys);
            n += per_tick;
        end
        if (tk >= 0) chk(n, tk, "divided ticks");
        @(posedge clk_sys);
        if (bad >= 0) irq_src[bad] <= 1'b1;
        if (wk >= 0) sleep_now;
        bus(0, pdm_pkg::OFS_STATUS, 0);
        chk(rd, {28'h0, m}, "stray sleep or source ignored");
        irq_src <= (wk >= 0) ? 24'h000001 << wk : 24'h000000;
        if (wk >= 0)
        begin
            accept_dly <= 4'h6;
            wait_wake(1'b1);
            bus(0, pdm_pkg::OFS_STATUS, 0);
            chk(rd, {28'h0, pdm_pkg::M_WAKING}, "waits for acceptance");
            wait_wake(1'b0);
            bus(0, pdm_pkg::OFS_STATUS, 0);
            irq_src <= 24'h0;
            chk(rd, {28'h0, res}, "resumed mode");
        end
        $display("mode test %h done", c);
    endtask : sleep_to
    initial
    begin
        {rst, hsel, hwrite, cmd_sleep, htrans, haddr, hwdata, irq_src, accept_dly} = {1'b1, 97'h0};
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs;
        sleep_to(7'h01, pdm_pkg::M_ACT_HIGH, pdm_pkg::PER_ALL, -1, -1, -1, pdm_pkg::M_ACT_HIGH);
        sleep_to(7'h00, pdm_pkg::M_SLP_HIGH, pdm_pkg::PER_ALL, 20, -1, -1, pdm_pkg::M_ACT_HIGH);
        for (int d = 0; d < 4; d++)
            sleep_to(7'h02 | 7'(d << 5), pdm_pkg::M_SLP_MED, pdm_pkg::PER_ALL, 21, -1, 16 >> d, pdm_pkg::M_ACT_MED);
        sleep_to(7'h09, pdm_pkg::M_SUBSLP, pdm_pkg::PER_SUBCLK, 6, 20, -1, pdm_pkg::M_SUBACT);
        sleep_to(7'h0c, pdm_pkg::M_WATCH, pdm_pkg::PER_WATCH, 0, 8, -1, pdm_pkg::M_ACT_HIGH);
        sleep_to(7'h04, pdm_pkg::M_STBY, 11'h000, 12, 9, -1, pdm_pkg::M_ACT_HIGH);
        sleep_to(7'h12, pdm_pkg::M_ACT_MED, pdm_pkg::PER_ALL, -1, -1, 16, pdm_pkg::M_ACT_MED);
        sleep_to(7'h1d, pdm_pkg::M_SUBACT, pdm_pkg::PER_SUBCLK, -1, -1, 0, pdm_pkg::M_SUBACT);
        sleep_to(7'h10, pdm_pkg::M_ACT_HIGH, pdm_pkg::PER_ALL, -1, -1, 128, pdm_pkg::M_ACT_HIGH);
        tally_and_finish;
    end
endmodule : power_down_mode_controller_tb
bind power_down_mode_controller pdm_asserts chk_u (.clk_sys, .rst, .sleep_req, .irq_accepted, .core_run,
    .core_on_subclock, .core_tick, .wake_req, .per_run, .per_on_subclock, .prescaler_count, .sysclk_osc_run,
    .port_hiz, .ext_irq_ignore, .aec_irq_block);
